//--- srxc_pkg.sv
// package: register layout, reset values, carriers and timing for the receiver control block
package srxc_pkg;

	// register byte offsets
	localparam logic [7:0] SRXC_OFS_CTRL = 8'h00;
	localparam logic [7:0] SRXC_OFS_TIMER = 8'h04;
	localparam logic [7:0] SRXC_OFS_AFE = 8'h08;
	localparam logic [7:0] SRXC_OFS_CAL = 8'h0C;
	localparam logic [7:0] SRXC_OFS_KP = 8'h10;
	localparam logic [7:0] SRXC_OFS_EQ = 8'h14;
	localparam logic [7:0] SRXC_OFS_EQCFG = 8'h18;
	localparam logic [7:0] SRXC_OFS_EQVAL = 8'h1C;
	localparam logic [7:0] SRXC_OFS_STATUS = 8'h20;

	// reset values of the writable words
	localparam logic [31:0] SRXC_RST_CTRL = 32'h0000_0003;
	localparam logic [31:0] SRXC_RST_TIMER = 32'h0303_0300;
	localparam logic [31:0] SRXC_RST_AFE = 32'h0044_0810;
	localparam logic [31:0] SRXC_RST_CAL = 32'h0000_0044;
	localparam logic [31:0] SRXC_RST_KP = 32'h0001_A3A3;
	localparam logic [31:0] SRXC_RST_EQ = 32'h0000_0000;
	localparam logic [31:0] SRXC_RST_EQCFG = 32'h0000_01C0;
	localparam logic [31:0] SRXC_RST_EQVAL = 32'h0004_2108; // four 5-bit fields, each 8

	// datapath width codes
	localparam logic [1:0] SRXC_W16 = 2'h0;
	localparam logic [1:0] SRXC_W32 = 2'h1;

	// termination calibration step time
	localparam int SRXC_CLK_NS = 10;
	localparam int SRXC_CAL_STEP_NS = 100;
	localparam int SRXC_CAL_STEP_CYC = (SRXC_CAL_STEP_NS + SRXC_CLK_NS - 1) / SRXC_CLK_NS;
	localparam int SRXC_FIFO_DEPTH = 16;

	typedef struct packed {
		logic [16:0] rsv;
		logic done_mask;
		logic eq_val;
		logic eq_ovr;
		logic idle_en;
		logic idle_ovr;
		logic pd_val_n;
		logic pd_ovr;
		logic pma_val;
		logic pma_ovr;
		logic pcs_val;
		logic pcs_ovr;
		logic main_val;
		logic main_ovr;
		logic [1:0] width_sel;
	} srxc_ctrl_t;

	typedef struct packed {
		logic [2:0] rsv3;
		logic [4:0] eq_dur;
		logic [2:0] rsv2;
		logic [4:0] pma_dur;
		logic [2:0] rsv1;
		logic [4:0] pcs_dur;
		logic [2:0] rsv0;
		logic [4:0] prescale;
	} srxc_timer_t;

	typedef struct packed {
		logic [15:0] rsv;
		logic [3:0] forced;
		logic [1:0] rsv1;
		logic cal_ovr;
		logic cal_start;
		logic [3:0] idle_bw;
		logic [3:0] idle_bias;
	} srxc_cal_t;

	typedef struct packed {
		logic [14:0] rsv1;
		logic eye_start;
		logic [1:0] rsv0;
		logic [5:0] mon2_phase;
		logic [3:0] ovr_mask;
		logic [1:0] rsvb;
		logic lock_cfg;
		logic adapt_en;
	} srxc_eq_t;

	// equalizer values, bit order matches the override mask
	typedef struct packed {
		logic [4:0] offset;
		logic [4:0] tap;
		logic [4:0] mon2;
		logic [4:0] mon1;
	} srxc_eqv_t;

	typedef struct packed {
		logic [63:0] data;
		logic [7:0] ctrl;
		logic [7:0] derr;
	} srxc_sym_t;

	typedef struct packed {
		logic [31:0] afe;
		logic [23:0] kp;
		logic [15:0] eq_config;
		logic [5:0] mon2_phase;
		logic eye_start;
		logic [3:0] idle_bias;
		logic [3:0] idle_bw;
	} srxc_afe_t;

	typedef enum logic [2:0] {
		SRXC_CAL_IDLE = 3'b001,
		SRXC_CAL_STEP = 3'b010,
		SRXC_CAL_DONE = 3'b100
	} srxc_cal_state_t;

endpackage : srxc_pkg

//--- srxc_top.sv
// receiver control block: registers, reset sequencing, calibration, overrides and data path
// Functional notes
// - width select 00 gives 16/20 bits, 01 gives 32/40, 1x gives 64/80; resets 3
// - decoder bypass adds eight control flags and eight disparity flags to the data
// - bypass packs each symbol as byte, then control flag at 8, disparity at 9
// - data path reset and pcs reset inputs act asynchronously
// - test mode override bits replace main and pcs reset ports; all reset to 0
// - test mode override bits replace pma reset and active low power down
// - test mode override bit replaces idle detector enable
// - test mode override bit replaces equalizer reset
// - pcs reset lasts programmed count times prescale; count 3, prescale 0
// - pma reset lasts programmed count times shared prescale; count 3
// - equalizer reset lasts programmed count times shared prescale; count 3
// - reset completion on output and status bit; debug gate blocks the output
// - calibration starts on enable, reports done and 4-bit result, override forces value
// - peaking code 0 max 31 min resets 16; gain 0 min 15 max resets 8
// - adaptation runs only when enabled; lock config applied; lock status readable
// - four-bit mask replaces adapted values by programmed ones per field
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns

// three stage pin synchroniser, output moves only when stages two and three agree
module srxc_sync3 (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic level
);
	logic [2:0] sh_r;
	logic level_nxt;

	always_comb begin
		level_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : level;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sh_r <= 3'h0;
			level <= 1'b0;
		end else begin
			sh_r <= {sh_r[1:0], pin};
			level <= level_nxt;
		end
	end
endmodule : srxc_sync3

// timed reset pulse: held while start is high, then max(dur, 1) * (prescale + 1) cycles
module srxc_rst_pulse (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [4:0] dur,
	input wire logic [4:0] prescale,
	output logic active_r
);
	logic [4:0] cnt_r, cnt_nxt, pre_r, pre_nxt;
	logic active_nxt;

	always_comb begin
		active_nxt = active_r;
		cnt_nxt = cnt_r;
		pre_nxt = pre_r;
		if (start) begin
			active_nxt = 1'b1;
			cnt_nxt = dur;
			pre_nxt = prescale;
		end else if (active_r) begin
			if (pre_r != 5'h0) begin
				pre_nxt = pre_r - 5'h1;
			end else if (cnt_r <= 5'h1) begin
				active_nxt = 1'b0; // a zero count still gives one prescaled period
			end else begin
				cnt_nxt = cnt_r - 5'h1;
				pre_nxt = prescale;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			active_r <= 1'b1;
			cnt_r <= 5'h3;
			pre_r <= 5'h0;
		end else begin
			active_r <= active_nxt;
			cnt_r <= cnt_nxt;
			pre_r <= pre_nxt;
		end
	end
endmodule : srxc_rst_pulse

// synchronous fifo with valid/ready on both sides and a flush input
module srxc_fifo #(
	parameter int W = 80,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];

	// memory has no reset so it can map onto ram
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
		end else if (clr) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0; // refuse input while flushed
		end else begin
			wp_r <= wp_r + AW'(push);
			rp_r <= rp_r + AW'(pop);
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != (AW+1)'(D));
		end
	end
endmodule : srxc_fifo

module srxc_top
	import srxc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic test_mode_pin,
	input wire logic rx_rst_in,
	input wire logic rx_pcs_rst_in,
	input wire logic rx_dec_en,
	input wire logic rx_pwrdn_in_n,
	input wire logic rx_idle_det_in,
	input wire logic rx_sym_valid,
	input wire srxc_sym_t rx_sym,
	output logic rx_in_ready,
	output logic rx_out_valid,
	input wire logic rx_out_ready,
	output logic [79:0] rx_out_data,
	output logic rx_rst_done,
	output logic rx_pcs_rst_out,
	output logic rx_pma_rst_out,
	output logic rx_eq_rst_out,
	output logic rx_pwrdn_out_n,
	output logic rx_idle_det_en_out,
	input wire logic cal_comp_pin,
	output logic [3:0] rx_term_code,
	input wire logic eq_locked_pin,
	input wire srxc_eqv_t eq_adapted,
	output srxc_eqv_t eq_applied,
	output logic eq_adapt_run,
	output logic eq_lock_cfg_out,
	output srxc_afe_t afe_cfg
);
	srxc_ctrl_t ctrl_r, ctrl_nxt;
	srxc_timer_t tmr_r, tmr_nxt;
	srxc_cal_t cal_r, cal_nxt;
	srxc_eq_t eq_r, eq_nxt;
	srxc_eqv_t eqv_r, eqv_nxt;
	logic [31:0] afe_r, afe_nxt, kp_r, kp_nxt, eqcfg_r, eqcfg_nxt, rdata_nxt;
	logic test_mode, cal_comp, eq_locked;
	logic main_assert, pcs_assert;
	logic [1:0] main_sync_r, pcs_sync_r;
	logic pcs_pulse, pma_pulse, eq_pulse, complete;

	srxc_sync3 u_sync_test (.clk(clk), .rst_b(rst_b), .pin(test_mode_pin), .level(test_mode));
	srxc_sync3 u_sync_comp (.clk(clk), .rst_b(rst_b), .pin(cal_comp_pin), .level(cal_comp));
	srxc_sync3 u_sync_lock (.clk(clk), .rst_b(rst_b), .pin(eq_locked_pin), .level(eq_locked));

	// register writes; each word keeps only its defined bits
	always_comb begin
		ctrl_nxt = ctrl_r;
		tmr_nxt = tmr_r;
		afe_nxt = afe_r;
		cal_nxt = cal_r;
		kp_nxt = kp_r;
		eq_nxt = eq_r;
		eqcfg_nxt = eqcfg_r;
		eqv_nxt = eqv_r;
		if (reg_wr) begin
			unique case (reg_addr)
				SRXC_OFS_CTRL: ctrl_nxt = srxc_ctrl_t'(reg_wdata & 32'h0000_7FFF);
				SRXC_OFS_TIMER: tmr_nxt = srxc_timer_t'(reg_wdata & 32'h1F1F_1F1F);
				SRXC_OFS_AFE: afe_nxt = reg_wdata & 32'h0177_0F1F;
				SRXC_OFS_CAL: cal_nxt = srxc_cal_t'(reg_wdata & 32'h0000_F3FF);
				SRXC_OFS_KP: kp_nxt = reg_wdata & 32'h00FF_FFFF;
				SRXC_OFS_EQ: eq_nxt = srxc_eq_t'(reg_wdata & 32'h0001_3FF3);
				SRXC_OFS_EQCFG: eqcfg_nxt = reg_wdata & 32'h0000_FFFF;
				SRXC_OFS_EQVAL: eqv_nxt = srxc_eqv_t'(reg_wdata[19:0]);
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= srxc_ctrl_t'(SRXC_RST_CTRL);
			tmr_r <= srxc_timer_t'(SRXC_RST_TIMER);
			afe_r <= SRXC_RST_AFE;
			cal_r <= srxc_cal_t'(SRXC_RST_CAL);
			kp_r <= SRXC_RST_KP;
			eq_r <= srxc_eq_t'(SRXC_RST_EQ);
			eqcfg_r <= SRXC_RST_EQCFG;
			eqv_r <= srxc_eqv_t'(SRXC_RST_EQVAL[19:0]);
		end else begin
			ctrl_r <= ctrl_nxt;
			tmr_r <= tmr_nxt;
			afe_r <= afe_nxt;
			cal_r <= cal_nxt;
			kp_r <= kp_nxt;
			eq_r <= eq_nxt;
			eqcfg_r <= eqcfg_nxt;
			eqv_r <= eqv_nxt;
		end
	end

	// reset sources: register value replaces the port in test mode; the mux output must be glitch free
	assign main_assert = (test_mode && ctrl_r.main_ovr) ? ctrl_r.main_val : rx_rst_in;
	assign pcs_assert = (test_mode && ctrl_r.pcs_ovr) ? ctrl_r.pcs_val : rx_pcs_rst_in;

	// asynchronous assertion, clocked release, so the inputs act without any clock edge
	always_ff @(posedge clk or negedge rst_b or posedge main_assert) begin
		if (!rst_b || main_assert) begin
			main_sync_r <= 2'h0;
		end else begin
			main_sync_r <= {main_sync_r[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_b or posedge pcs_assert) begin
		if (!rst_b || pcs_assert) begin
			pcs_sync_r <= 2'h0;
		end else begin
			pcs_sync_r <= {pcs_sync_r[0], 1'b1};
		end
	end

	// three timed pulses share the prescaler; main reset restarts all of them
	srxc_rst_pulse u_pcs (.clk(clk), .rst_b(rst_b), .start(!main_sync_r[1] || !pcs_sync_r[1]),
		.dur(tmr_r.pcs_dur), .prescale(tmr_r.prescale), .active_r(pcs_pulse));
	srxc_rst_pulse u_pma (.clk(clk), .rst_b(rst_b), .start(!main_sync_r[1]),
		.dur(tmr_r.pma_dur), .prescale(tmr_r.prescale), .active_r(pma_pulse));
	srxc_rst_pulse u_eq (.clk(clk), .rst_b(rst_b), .start(!main_sync_r[1]),
		.dur(tmr_r.eq_dur), .prescale(tmr_r.prescale), .active_r(eq_pulse));

	logic pma_rst_nxt, eq_rst_nxt, done_nxt;

	// override muxes and completion; completion waits for every overridden reset too
	always_comb begin
		pma_rst_nxt = (test_mode && ctrl_r.pma_ovr) ? ctrl_r.pma_val : pma_pulse;
		eq_rst_nxt = (test_mode && ctrl_r.eq_ovr) ? ctrl_r.eq_val : eq_pulse;
		done_nxt = main_sync_r[1] && !pcs_pulse && !pma_rst_nxt && !eq_rst_nxt;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_pcs_rst_out <= 1'b1;
			rx_pma_rst_out <= 1'b1;
			rx_eq_rst_out <= 1'b1;
			complete <= 1'b0;
			rx_rst_done <= 1'b0;
			rx_pwrdn_out_n <= 1'b0;
			rx_idle_det_en_out <= 1'b0;
		end else begin
			rx_pcs_rst_out <= pcs_pulse;
			rx_pma_rst_out <= pma_rst_nxt;
			rx_eq_rst_out <= eq_rst_nxt;
			complete <= done_nxt;
			rx_rst_done <= done_nxt && !ctrl_r.done_mask;
			rx_pwrdn_out_n <= (test_mode && ctrl_r.pd_ovr) ? ctrl_r.pd_val_n : rx_pwrdn_in_n;
			rx_idle_det_en_out <= (test_mode && ctrl_r.idle_ovr) ? ctrl_r.idle_en : rx_idle_det_in;
		end
	end

	// termination calibration: step the code until the comparator trips or the code tops out
	srxc_cal_state_t cal_st_r, cal_st_nxt;
	logic [7:0] cal_tmr_r, cal_tmr_nxt;
	logic [3:0] cal_code_r, cal_code_nxt, cal_res_r, cal_res_nxt;
	logic cal_fin_r, cal_fin_nxt, cal_start_q;

	always_comb begin
		cal_st_nxt = cal_st_r;
		cal_tmr_nxt = cal_tmr_r;
		cal_code_nxt = cal_code_r;
		cal_res_nxt = cal_res_r;
		cal_fin_nxt = cal_fin_r;
		unique case (cal_st_r)
			SRXC_CAL_IDLE: begin
				if (cal_r.cal_start && !cal_start_q) begin
					cal_st_nxt = SRXC_CAL_STEP;
					cal_fin_nxt = 1'b0;
					cal_code_nxt = 4'h0;
					cal_tmr_nxt = 8'(SRXC_CAL_STEP_CYC - 1);
				end
			end
			SRXC_CAL_STEP: begin
				if (cal_tmr_r != 8'h0) begin
					cal_tmr_nxt = cal_tmr_r - 8'h1; // let the analog settle each step
				end else if (cal_comp || cal_code_r == 4'hF) begin
					cal_res_nxt = cal_code_r;
					cal_st_nxt = SRXC_CAL_DONE;
				end else begin
					cal_code_nxt = cal_code_r + 4'h1;
					cal_tmr_nxt = 8'(SRXC_CAL_STEP_CYC - 1);
				end
			end
			SRXC_CAL_DONE: begin
				cal_fin_nxt = 1'b1;
				cal_st_nxt = SRXC_CAL_IDLE;
			end
			default: cal_st_nxt = SRXC_CAL_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_st_r <= SRXC_CAL_IDLE;
			cal_tmr_r <= 8'h0;
			cal_code_r <= 4'h0;
			cal_res_r <= 4'h0;
			cal_fin_r <= 1'b1;
			cal_start_q <= 1'b0;
			rx_term_code <= 4'h0;
		end else begin
			cal_st_r <= cal_st_nxt;
			cal_tmr_r <= cal_tmr_nxt;
			cal_code_r <= cal_code_nxt;
			cal_res_r <= cal_res_nxt;
			cal_fin_r <= cal_fin_nxt;
			cal_start_q <= cal_r.cal_start;
			// the forced code wins when overridden; otherwise the running code drives the resistor while calibrating
			rx_term_code <= cal_r.cal_ovr ? cal_r.forced :
				(cal_st_r == SRXC_CAL_STEP) ? cal_code_r : cal_res_r;
		end
	end

	// equalizer: masked fields take the programmed value, adaptation held while in reset
	srxc_eqv_t eqv_mix;
	always_comb begin
		eqv_mix.mon1 = eq_r.ovr_mask[0] ? eqv_r.mon1 : eq_adapted.mon1;
		eqv_mix.mon2 = eq_r.ovr_mask[1] ? eqv_r.mon2 : eq_adapted.mon2;
		eqv_mix.tap = eq_r.ovr_mask[2] ? eqv_r.tap : eq_adapted.tap;
		eqv_mix.offset = eq_r.ovr_mask[3] ? eqv_r.offset : eq_adapted.offset;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eq_applied <= srxc_eqv_t'(SRXC_RST_EQVAL[19:0]);
			eq_adapt_run <= 1'b0;
			eq_lock_cfg_out <= 1'b0;
			afe_cfg <= '0;
		end else begin
			eq_applied <= eqv_mix;
			eq_adapt_run <= eq_r.adapt_en && !eq_rst_nxt;
			eq_lock_cfg_out <= eq_r.lock_cfg;
			afe_cfg <= '{afe: afe_r, kp: kp_r[23:0], eq_config: eqcfg_r[15:0], mon2_phase: eq_r.mon2_phase,
				eye_start: eq_r.eye_start, idle_bias: cal_r.idle_bias, idle_bw: cal_r.idle_bw};
		end
	end

	// read data stands in the cycle after the strobe only
	always_comb begin
		rdata_nxt = 32'h0;
		if (reg_rd) begin
			unique case (reg_addr)
				SRXC_OFS_CTRL: rdata_nxt = ctrl_r;
				SRXC_OFS_TIMER: rdata_nxt = tmr_r;
				SRXC_OFS_AFE: rdata_nxt = afe_r;
				SRXC_OFS_CAL: rdata_nxt = cal_r;
				SRXC_OFS_KP: rdata_nxt = kp_r;
				SRXC_OFS_EQ: rdata_nxt = eq_r;
				SRXC_OFS_EQCFG: rdata_nxt = eqcfg_r;
				SRXC_OFS_EQVAL: rdata_nxt = {12'h0, eqv_r};
				SRXC_OFS_STATUS: rdata_nxt = {22'h0, eq_applied.offset[0], eq_applied.mon2[0], eq_applied.tap[0],
					eq_locked, cal_res_r, cal_fin_r, complete};
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// data path: fifo flushed during pcs reset, then a packing output stage
	srxc_sym_t fifo_q;
	logic fifo_valid, fifo_pop;
	logic [79:0] pack;

	srxc_fifo #(.W($bits(srxc_sym_t)), .D(SRXC_FIFO_DEPTH)) u_fifo (.clk(clk), .rst_b(rst_b),
		.clr(rx_pcs_rst_out), .in_valid(rx_sym_valid), .in_ready(rx_in_ready), .in_data(rx_sym),
		.out_valid(fifo_valid), .out_ready(fifo_pop), .out_data(fifo_q));

	assign fifo_pop = !rx_out_valid || rx_out_ready;

	always_comb begin
		pack = 80'h0;
		if (rx_dec_en) begin
			pack[63:0] = fifo_q.data;
		end else begin
			for (int n = 0; n < 8; n++) begin
				pack[n*10 +: 10] = {fifo_q.derr[n], fifo_q.ctrl[n], fifo_q.data[n*8 +: 8]};
			end
		end
		// trim to the selected width; unused lanes read zero
		if (ctrl_r.width_sel == SRXC_W16) begin
			pack[79:20] = 60'h0;
			if (rx_dec_en) pack[19:16] = 4'h0;
		end else if (ctrl_r.width_sel == SRXC_W32) begin
			pack[79:40] = 40'h0;
			if (rx_dec_en) pack[39:32] = 8'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_out_valid <= 1'b0;
			rx_out_data <= 80'h0;
		end else if (rx_pcs_rst_out) begin
			rx_out_valid <= 1'b0;
		end else if (fifo_pop) begin
			rx_out_valid <= fifo_valid;
			if (fifo_valid) rx_out_data <= pack;
		end
	end

	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_done_gated: assert property (ctrl_r.done_mask |=> !rx_rst_done) else $error("done shown while gated");
	a_done_after_rst: assert property ($rose(rx_rst_done) |-> !rx_pcs_rst_out && !rx_pma_rst_out)
		else $error("done while reset active");
	// default timer: count 3, prescale 0, so the pulse stands three cycles after release
	a_pcs_default_len: assert property ($rose(pcs_sync_r[1]) && main_sync_r[1] &&
		tmr_r == srxc_timer_t'(SRXC_RST_TIMER) |-> pcs_pulse [*3] ##1 !pcs_pulse) else $error("pcs pulse length");
	a_pma_override: assert property (test_mode && ctrl_r.pma_ovr |=>
		rx_pma_rst_out == $past(ctrl_r.pma_val)) else $error("pma override ignored");
	a_eq_override: assert property (test_mode && ctrl_r.eq_ovr |=>
		rx_eq_rst_out == $past(ctrl_r.eq_val)) else $error("eq override ignored");
	a_idle_override: assert property (test_mode && ctrl_r.idle_ovr |=>
		rx_idle_det_en_out == $past(ctrl_r.idle_en)) else $error("idle override ignored");
	a_adapt_gate: assert property (!eq_r.adapt_en |=> !eq_adapt_run) else $error("adapt without enable");
	a_mask_tap: assert property (eq_r.ovr_mask[2] |=> eq_applied.tap == $past(eqv_r.tap))
		else $error("tap override lost");
	a_cal_force: assert property (cal_r.cal_ovr |=> rx_term_code == $past(cal_r.forced))
		else $error("cal override lost");
	a_pack_bypass: assert property (!rx_dec_en && fifo_pop && fifo_valid &&
		!rx_pcs_rst_out && ctrl_r.width_sel[1] |=> rx_out_data[9:8] == $past({fifo_q.derr[0], fifo_q.ctrl[0]}))
		else $error("symbol packing");
	a_width16: assert property (rx_out_valid && $past(ctrl_r.width_sel) == SRXC_W16 &&
		$stable(ctrl_r.width_sel) |-> rx_out_data[79:20] == 60'h0 || $stable(rx_out_data)) else $error("width trim");

	c_reset_done: cover property ($rose(rx_rst_done));
	c_cal_run: cover property (cal_st_r == SRXC_CAL_STEP ##[1:200] cal_fin_r);
	c_fifo_full: cover property (!rx_in_ready && !rx_pcs_rst_out);
	c_bypass_out: cover property (rx_out_valid && rx_out_ready && !rx_dec_en);

endmodule : srxc_top

//--- srxc_fabric_model.sv
// fabric-side model: queued symbol source and a sink that can stall
`timescale 1ns/1ns
module srxc_fabric_model
	import srxc_pkg::*;
(
	input wire logic clk,
	input wire logic stall,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic [79:0] out_data,
	output logic sym_valid,
	output srxc_sym_t sym,
	output logic out_ready,
	output int rcv_count,
	output logic [79:0] last_data
);
	srxc_sym_t q[$];
	int head;

	// called off the clock edge so the queue never races the source process
	task automatic push(input srxc_sym_t w);
		q.push_back(w);
	endtask : push

	initial begin
		head = 0;
		sym_valid = 1'b0;
		sym = '0;
		out_ready = 1'b1;
		rcv_count = 0;
		last_data = '0;
	end

	// word and valid are held until the edge that sees ready; idle data toggles so stale values never match
	always @(posedge clk) begin
		if (sym_valid && in_ready) begin
			head = head + 1;
		end
		sym_valid <= (q.size() > head);
		sym <= (q.size() > head) ? q[head] : ~sym;
		out_ready <= !stall;
		if (out_valid && out_ready) begin
			rcv_count <= rcv_count + 1;
			last_data <= out_data;
		end
	end
endmodule : srxc_fabric_model

//--- srxc_top_tb.sv
// testbench for the receiver control block: register, override, timer, calibration and data path tests
`timescale 1ns/1ns
module srxc_top_tb
	import srxc_pkg::*;
;
	logic clk, rst_b, reg_wr, reg_rd, test_mode_pin, rx_rst_in, rx_pcs_rst_in, rx_dec_en, rx_pwrdn_in_n;
	logic rx_idle_det_in, rx_sym_valid, rx_in_ready, rx_out_valid, rx_out_ready, rx_rst_done, rx_pcs_rst_out;
	logic rx_pma_rst_out, rx_eq_rst_out, rx_pwrdn_out_n, rx_idle_det_en_out, cal_comp_pin, eq_locked_pin;
	logic eq_adapt_run, eq_lock_cfg_out, stall;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [79:0] rx_out_data, last_data;
	logic [3:0] rx_term_code;
	srxc_sym_t rx_sym, s;
	srxc_eqv_t eq_adapted, eq_applied;
	srxc_afe_t afe_cfg;
	int rcv_count, err_total, check_count, n1, n2;
	logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
	logic [31:0] rst_val[8] = '{SRXC_RST_CTRL, SRXC_RST_TIMER, SRXC_RST_AFE, SRXC_RST_CAL, SRXC_RST_KP,
		SRXC_RST_EQ, SRXC_RST_EQCFG, SRXC_RST_EQVAL};

	srxc_top srxc_top_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .test_mode_pin(test_mode_pin), .rx_rst_in(rx_rst_in),
		.rx_pcs_rst_in(rx_pcs_rst_in), .rx_dec_en(rx_dec_en), .rx_pwrdn_in_n(rx_pwrdn_in_n),
		.rx_idle_det_in(rx_idle_det_in), .rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .rx_in_ready(rx_in_ready),
		.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data),
		.rx_rst_done(rx_rst_done), .rx_pcs_rst_out(rx_pcs_rst_out), .rx_pma_rst_out(rx_pma_rst_out),
		.rx_eq_rst_out(rx_eq_rst_out), .rx_pwrdn_out_n(rx_pwrdn_out_n), .rx_idle_det_en_out(rx_idle_det_en_out),
		.cal_comp_pin(cal_comp_pin), .rx_term_code(rx_term_code), .eq_locked_pin(eq_locked_pin),
		.eq_adapted(eq_adapted), .eq_applied(eq_applied), .eq_adapt_run(eq_adapt_run),
		.eq_lock_cfg_out(eq_lock_cfg_out), .afe_cfg(afe_cfg));
	srxc_fabric_model srxc_fabric_model_inst (.clk(clk), .stall(stall), .in_ready(rx_in_ready),
		.out_valid(rx_out_valid), .out_data(rx_out_data), .sym_valid(rx_sym_valid), .sym(rx_sym),
		.out_ready(rx_out_ready), .rcv_count(rcv_count), .last_data(last_data));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic settle;
		repeat (20) @(posedge clk);
		#1;
	endtask : settle

	task automatic wait_rcv(input int n);
		for (int i = 0; i < 300 && rcv_count < n; i++) @(posedge clk);
		chk(rcv_count, n);
	endtask : wait_rcv

	// length of the pcs reset pulse after a port reset request
	task automatic pcs_len(output int n);
		@(posedge clk);
		rx_pcs_rst_in <= 1'b1;
		@(posedge clk);
		rx_pcs_rst_in <= 1'b0;
		n = 0;
		repeat (150) begin
			@(posedge clk);
			#1 n += rx_pcs_rst_out;
		end
	endtask : pcs_len

	function automatic logic [79:0] pack(input srxc_sym_t x);
		for (int i = 0; i < 8; i++) pack[10*i +: 10] = {x.derr[i], x.ctrl[i], x.data[8*i +: 8]};
	endfunction : pack

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	initial begin
		#200_000; // the tests need about a thousand cycles
		err_total++;
		wrap_up();
	end

	initial begin
		{rst_b, reg_wr, reg_rd, test_mode_pin, rx_rst_in, rx_pcs_rst_in, rx_dec_en, stall, cal_comp_pin} = '0;
		{rx_pwrdn_in_n, rx_idle_det_in, eq_locked_pin} = 3'b101;
		reg_addr = '0;
		reg_wdata = '0;
		eq_adapted = {5'h3, 5'h3, 5'h3, 5'h3};
		err_total = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		foreach (ofs[i]) begin
			rd(ofs[i], d);
			chk(d, rst_val[i]);
		end
		settle();
		rd(SRXC_OFS_STATUS, d);
		chk(d[6:0], 7'h43);
		chk(rx_rst_done, 1'b1);
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, d);
		chk(d, 32'h0);
		wr(SRXC_OFS_AFE, 32'h0044_0F1F);
		rd(SRXC_OFS_AFE, d);
		chk(d, 32'h0044_0F1F);
		chk(afe_cfg.afe, 32'h0044_0F1F);
		$display("test registers done");
		// every override forced on in test mode, ports held at the opposite level
		test_mode_pin <= 1'b1;
		rx_pwrdn_in_n <= 1'b0;
		wr(SRXC_OFS_CTRL, 32'h3FFF);
		settle();
		chk({rx_pcs_rst_out, rx_pma_rst_out, rx_eq_rst_out, rx_pwrdn_out_n, rx_idle_det_en_out, rx_rst_done},
			6'h3E);
		wr(SRXC_OFS_CTRL, 32'h3);
		test_mode_pin <= 1'b0;
		rx_pwrdn_in_n <= 1'b1;
		settle();
		chk({rx_pwrdn_out_n, rx_idle_det_en_out, rx_rst_done}, 3'h5);
		wr(SRXC_OFS_CTRL, 32'h4003);
		settle();
		rd(SRXC_OFS_STATUS, d);
		chk({rx_rst_done, d[0]}, 2'b01);
		wr(SRXC_OFS_CTRL, 32'h3);
		$display("test overrides done");
		wr(SRXC_OFS_TIMER, 32'h0303_0201);
		pcs_len(n1);
		wr(SRXC_OFS_TIMER, 32'h0303_0501);
		pcs_len(n2);
		chk(n2 - n1, 6);
		$display("test timers done");
		wr(SRXC_OFS_CAL, 32'h144);
		settle();
		d = '0;
		for (int i = 0; i < 150 && d[1] !== 1'b1; i++) rd(SRXC_OFS_STATUS, d);
		chk(d[5:1], 5'h1F);
		wr(SRXC_OFS_CAL, 32'hA244);
		settle();
		chk(rx_term_code, 4'hA);
		// comparator already tripped: the first code is the result
		cal_comp_pin <= 1'b1;
		wr(SRXC_OFS_CAL, 32'h144);
		settle();
		rd(SRXC_OFS_STATUS, d);
		chk({d[5:1], rx_term_code}, 9'h010);
		$display("test calibration done");
		wr(SRXC_OFS_EQVAL, {5'h15, 5'h15, 5'h15, 5'h15});
		for (int i = 0; i < 4; i++) begin
			wr(SRXC_OFS_EQ, 32'h3 | (32'h10 << i));
			settle();
			chk({eq_adapt_run, eq_lock_cfg_out, eq_applied}, {2'b11, 20'h18C63 ^ (20'h16 << (5*i))});
		end
		$display("test equalizer done");
		s = {64'h0123_4567_89AB_CDEF, 8'hA5, 8'h3C};
		for (int w = 0; w < 4; w++) begin
			rx_dec_en <= (w == 2);
			wr(SRXC_OFS_CTRL, (w == 2) ? 32'h3 : w);
			@(negedge clk) srxc_fabric_model_inst.push(s);
			wait_rcv(w + 1);
			chk(last_data, (w == 2) ? {16'h0, s.data} :
				pack(s) & ((80'h1 << (w == 0 ? 20 : w == 1 ? 40 : 80)) - 1));
		end
		stall <= 1'b1;
		for (int i = 0; i < 24; i++) @(negedge clk) srxc_fabric_model_inst.push(s ^ i);
		settle();
		settle();
		chk(rx_in_ready, 1'b0);
		stall <= 1'b0;
		wait_rcv(28);
		chk(last_data, pack(s ^ 23));
		$display("test data path done");
		wrap_up();
	end
endmodule : srxc_top_tb
